/* include/flash_ctl_pkg.sv */
// constants, state encoding and timing counts for the flash erase and power control block
// assumes a 250 MHz system clock and a serial link clock supplied by the bus host

package flash_ctl_pkg;

    // ------------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------------
    localparam int unsigned CNT_W          = 6;      // bit counter width, saturates
    localparam logic [5:0]  BITS_OPCODE    = 6'h08;  // opcode alone
    localparam logic [5:0]  BITS_OPC_ADDR  = 6'h20;  // opcode plus three address bytes
    localparam logic [5:0]  BITS_SAT       = 6'h3f;  // counter ceiling
    localparam int unsigned SHIFT_W        = 32;     // shift register width
    localparam int unsigned ADDR_KEEP      = 19;     // address bits 18..0 kept
    localparam int unsigned PAGE_LSB       = 8;      // 256-byte page
    localparam int unsigned SECTOR_LSB     = 16;     // 64 KB sector
    localparam logic [2:0]  PROT_SECTOR    = 3'h0;   // sector guarded by the protect input

    // ------------------------------------------------------------------
    // opcodes (values are arbitrary, not given for this block)
    // ------------------------------------------------------------------
    localparam logic [7:0]  OP_UNLOCK      = 8'h11;
    localparam logic [7:0]  OP_PAGE_CLEAR  = 8'h22;
    localparam logic [7:0]  OP_BLOCK_CLEAR = 8'h33;
    localparam logic [7:0]  OP_DEEP_SLEEP  = 8'h44;
    localparam logic [7:0]  OP_WAKE        = 8'h55;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ            = 250;
    localparam int unsigned HOLDOFF_TIME_MS    = 10;
    localparam int unsigned HOLDOFF_CYCLES_DEF = HOLDOFF_TIME_MS * 1000 * CLK_MHZ;
    localparam int unsigned PAGE_CLEAR_DEF     = 2000;   // plain default
    localparam int unsigned BLOCK_CLEAR_DEF    = 20000;  // plain default
    localparam int unsigned SLEEP_ENTRY_DEF    = 100;    // plain default
    localparam int unsigned WAKE_DEF           = 100;    // plain default
    localparam int unsigned TIMER_W            = 32;

    // ------------------------------------------------------------------
    // control states
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE        = 5'b00001,
        ST_CLEAR       = 5'b00010,
        ST_SLEEP_ENTRY = 5'b00100,
        ST_SLEEP       = 5'b01000,
        ST_WAKE        = 5'b10000
    } state_e;

endpackage : flash_ctl_pkg

/* verilog/flash_erase_power_ctl.sv */
// command handling for page clear, block clear, deep sleep and wake of a serial flash
// assumes the array below runs the actual clearing on clear_start_o and reports other cycles on ext_cycle_busy_i
`timescale 1ns/1ps
`default_nettype none

module flash_erase_power_ctl #(
    parameter int unsigned PAGE_CLEAR_CYCLES  = flash_ctl_pkg::PAGE_CLEAR_DEF,
    parameter int unsigned BLOCK_CLEAR_CYCLES = flash_ctl_pkg::BLOCK_CLEAR_DEF,
    parameter int unsigned SLEEP_ENTRY_CYCLES = flash_ctl_pkg::SLEEP_ENTRY_DEF,
    parameter int unsigned WAKE_CYCLES        = flash_ctl_pkg::WAKE_DEF,
    parameter int unsigned HOLDOFF_CYCLES     = flash_ctl_pkg::HOLDOFF_CYCLES_DEF
) (
    // system clock and reset
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    // serial link pins
    input  wire logic        sclk_i,
    input  wire logic        cs_n_i,
    input  wire logic        sdi_i,
    // reset and protection pins
    input  wire logic        reset_n_i,
    input  wire logic        por_hold_i,
    input  wire logic        hw_protect_i,
    // array side
    input  wire logic        ext_cycle_busy_i,
    output logic             clear_start_o,
    output logic             clear_block_o,
    output logic [18:0]      clear_addr_o,
    // status
    output logic             busy_flag_o,
    output logic             write_unlock_latch_o,
    output logic             deep_sleep_o,
    output logic             standby_o
);

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    // link-side state, clocked by the host's serial clock
    typedef struct packed {
        logic [5:0]  count;          // bits seen in this frame, saturating
        logic [31:0] sh;             // last 32 bits shifted in, newest in bit 0
    } link_s;

    // system-side state
    typedef struct packed {
        logic [1:0]           cs_s;         // select synchroniser
        logic [1:0]           por_s;        // power-on hold synchroniser
        logic [1:0]           rstn_s;       // reset pin synchroniser
        logic [1:0]           prot_s;       // protect pin synchroniser
        logic                 cs_prev;      // last synchronised select, for edge
        flash_ctl_pkg::state_e state;       // control state
        logic [31:0]          timer;        // duration down-counter
        logic [31:0]          holdoff;      // write hold-off up-counter
        logic                 holdoff_done; // hold-off elapsed
        logic                 unlock;       // write-unlock latch
        logic                 busy;         // busy flag
        logic                 sleep;        // deep-sleep mode
        logic                 standby;      // standby indication
        logic                 clr_start;    // one-cycle clear request
        logic                 clr_block;    // 1 = sector, 0 = page
        logic [18:0]          clr_addr;     // aligned base of the region
    } sys_s;

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // a page lies in the guarded sector, so one test serves both clear kinds
    function automatic logic is_protected(input logic [18:0] addr, input logic prot);
        is_protected = prot && (addr[18:flash_ctl_pkg::SECTOR_LSB] == flash_ctl_pkg::PROT_SECTOR);
    endfunction : is_protected

    // true when the frame was an opcode of exactly the given bit length
    function automatic logic frame_is(input logic [5:0] bits, input logic [7:0] op,
                                      input logic [5:0] want_bits, input logic [7:0] want_op);
        frame_is = (bits == want_bits) && (op == want_op);
    endfunction : frame_is

    // ------------------------------------------------------------------
    // link domain
    // ------------------------------------------------------------------
    link_s link;                 // registered link state
    link_s next_link;            // next link state
    logic  in_frame;             // set by first clock edge of a frame

    // frame marker, ended by the frame's own select signal since the
    // serial clock stands still between frames
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            in_frame <= 1'b0;
        end else begin
            in_frame <= 1'b1;
        end
    end

    // shift and count; the first edge of a frame restarts the count, so
    // the values of the last frame stay readable after select rises
    always_comb begin
        next_link    = link;
        next_link.sh = {link.sh[30:0], sdi_i};
        if (!in_frame) begin
            next_link.count = 6'h01;
        end else if (link.count != flash_ctl_pkg::BITS_SAT) begin
            next_link.count = link.count + 6'h01;
        end
    end

    // power-on hold clears the link logic so a bare select pulse decodes as nothing
    always_ff @(posedge sclk_i or posedge por_hold_i) begin
        if (por_hold_i) begin
            link <= '0;
        end else begin
            link <= next_link;
        end
    end

    // ------------------------------------------------------------------
    // system domain
    // ------------------------------------------------------------------
    sys_s st;                    // registered state
    sys_s next_st;               // next state
    logic        cs_q;           // synchronised select, high = deselected
    logic        cs_rise;        // select just went high
    logic        hold;           // internal reset from power-on hold or reset pin
    logic [5:0]  bits;           // bit count of the finished frame
    logic [7:0]  op;             // opcode of the finished frame
    logic [18:0] addr;           // used address bits of the finished frame
    logic        is_page;        // valid page clear frame
    logic        is_block;       // valid block clear frame

    // frame decode; link values are quasi-static once select is high and
    // are only looked at after select has passed the synchroniser
    always_comb begin
        cs_q     = st.cs_s[1];
        cs_rise  = cs_q && !st.cs_prev;
        hold     = st.por_s[1] || !st.rstn_s[1];
        bits     = link.count;
        op       = (bits == flash_ctl_pkg::BITS_OPCODE) ? link.sh[7:0] : link.sh[31:24];
        addr     = link.sh[18:0];
        is_page  = frame_is(bits, op, flash_ctl_pkg::BITS_OPC_ADDR, flash_ctl_pkg::OP_PAGE_CLEAR);
        is_block = frame_is(bits, op, flash_ctl_pkg::BITS_OPC_ADDR, flash_ctl_pkg::OP_BLOCK_CLEAR);
    end

    // control state machine
    always_comb begin
        next_st           = st;
        // synchronisers: first stage read only by the second
        next_st.cs_s      = {st.cs_s[0], cs_n_i};
        next_st.por_s     = {st.por_s[0], por_hold_i};
        next_st.rstn_s    = {st.rstn_s[0], reset_n_i};
        next_st.prot_s    = {st.prot_s[0], hw_protect_i};
        next_st.cs_prev   = cs_q;
        next_st.clr_start = 1'b0;

        // write hold-off after power-on hold release
        if (!st.holdoff_done) begin
            next_st.holdoff = st.holdoff + 32'h1;
            if (st.holdoff >= 32'(HOLDOFF_CYCLES - 1)) begin
                next_st.holdoff_done = 1'b1;
            end
        end

        if (st.timer != 32'h0) begin
            next_st.timer = st.timer - 32'h1;
        end

        case (st.state)
            flash_ctl_pkg::ST_IDLE: begin
                // a cycle in the array refuses every command here
                if (cs_rise && !ext_cycle_busy_i) begin
                    if (frame_is(bits, op, flash_ctl_pkg::BITS_OPCODE, flash_ctl_pkg::OP_UNLOCK)) begin
                        // unlock only once the hold-off has run out
                        if (st.holdoff_done) begin
                            next_st.unlock = 1'b1;
                        end
                    end else if (frame_is(bits, op, flash_ctl_pkg::BITS_OPCODE,
                                          flash_ctl_pkg::OP_DEEP_SLEEP)) begin
                        next_st.state = flash_ctl_pkg::ST_SLEEP_ENTRY;
                        next_st.timer = 32'(SLEEP_ENTRY_CYCLES);
                    end else if ((is_page || is_block) && st.unlock && st.holdoff_done
                                 && !is_protected(addr, st.prot_s[1])) begin
                        next_st.state     = flash_ctl_pkg::ST_CLEAR;
                        next_st.busy      = 1'b1;
                        next_st.unlock    = 1'b0;
                        next_st.clr_start = 1'b1;
                        next_st.clr_block = is_block;
                        if (is_block) begin
                            next_st.clr_addr = {addr[18:flash_ctl_pkg::SECTOR_LSB], 16'h0000};
                            next_st.timer    = 32'(BLOCK_CLEAR_CYCLES);
                        end else begin
                            next_st.clr_addr = {addr[18:flash_ctl_pkg::PAGE_LSB], 8'h00};
                            next_st.timer    = 32'(PAGE_CLEAR_CYCLES);
                        end
                    end
                end
            end
            flash_ctl_pkg::ST_CLEAR: begin
                // frames arriving now are dropped, the cycle runs on
                if (st.timer <= 32'h1) begin
                    next_st.busy  = 1'b0;
                    next_st.state = flash_ctl_pkg::ST_IDLE;
                end
            end
            flash_ctl_pkg::ST_SLEEP_ENTRY: begin
                // entry delay; frames in this window are ignored
                if (st.timer <= 32'h1) begin
                    next_st.sleep = 1'b1;
                    next_st.state = flash_ctl_pkg::ST_SLEEP;
                end
            end
            flash_ctl_pkg::ST_SLEEP: begin
                // only a clean wake frame counts; extra clocks spoil it
                if (cs_rise && frame_is(bits, op, flash_ctl_pkg::BITS_OPCODE,
                                        flash_ctl_pkg::OP_WAKE)) begin
                    next_st.state = flash_ctl_pkg::ST_WAKE;
                    next_st.timer = 32'(WAKE_CYCLES);
                end
            end
            flash_ctl_pkg::ST_WAKE: begin
                // host keeps select high meanwhile; mode ends after the delay
                if (st.timer <= 32'h1) begin
                    next_st.sleep = 1'b0;
                    next_st.state = flash_ctl_pkg::ST_IDLE;
                end
            end
            default: begin
                next_st.state = flash_ctl_pkg::ST_IDLE;
            end
        endcase

        // deselected and nothing running means standby, not deep sleep
        next_st.standby = cs_q && (next_st.state == flash_ctl_pkg::ST_IDLE)
                          && !ext_cycle_busy_i;

        // power-on hold or reset pin: everything but the synchronisers and cs_prev returns
        // to the power-up state and the hold-off starts again
        if (hold) begin
            next_st.state        = flash_ctl_pkg::ST_IDLE;
            next_st.timer        = 32'h0;
            next_st.holdoff      = 32'h0;
            next_st.holdoff_done = 1'b0;
            next_st.unlock       = 1'b0;
            next_st.busy         = 1'b0;
            next_st.sleep        = 1'b0;
            next_st.standby      = 1'b0;
            next_st.clr_start    = 1'b0;
            next_st.clr_block    = 1'b0;
            next_st.clr_addr     = 19'h00000;
        end
    end

    // system register; the reset pin and power-on hold act through hold so
    // their synchronisers keep running
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st.cs_s         <= 2'b11;
            st.por_s        <= 2'b11;
            st.rstn_s       <= 2'b00;
            st.prot_s       <= 2'b00;
            st.cs_prev      <= 1'b1;
            st.state        <= flash_ctl_pkg::ST_IDLE;
            st.timer        <= 32'h0;
            st.holdoff      <= 32'h0;
            st.holdoff_done <= 1'b0;
            st.unlock       <= 1'b0;
            st.busy         <= 1'b0;
            st.sleep        <= 1'b0;
            st.standby      <= 1'b0;
            st.clr_start    <= 1'b0;
            st.clr_block    <= 1'b0;
            st.clr_addr     <= 19'h00000;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs, straight from flip-flops
    // ------------------------------------------------------------------
    assign busy_flag_o          = st.busy;
    assign write_unlock_latch_o = st.unlock;
    assign deep_sleep_o         = st.sleep;
    assign standby_o            = st.standby;
    assign clear_start_o        = st.clr_start;
    assign clear_block_o        = st.clr_block;
    assign clear_addr_o         = st.clr_addr;

endmodule : flash_erase_power_ctl

`default_nettype wire

/* tb/flash_ctl_properties.sv */
// checker for the flash erase and power control block
// assumes it is bound into flash_erase_power_ctl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module flash_ctl_properties #(
    parameter int unsigned PAGE_CLEAR_CYCLES  = 60,
    parameter int unsigned BLOCK_CLEAR_CYCLES = 90
) (
    // system clock and reset
    input wire logic        clock_i,
    input wire logic        sys_rst_i,
    // watched pins
    input wire logic        hw_protect_i,
    input wire logic        clear_start_o,
    input wire logic        clear_block_o,
    input wire logic [18:0] clear_addr_o,
    input wire logic        busy_flag_o,
    input wire logic        write_unlock_latch_o,
    input wire logic        deep_sleep_o,
    input wire logic        standby_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    // ------------------------------------------------------------------
    // busy length counter, too long for a repetition
    // ------------------------------------------------------------------
    logic [31:0] busy_cnt; // busy cycles seen so far
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !busy_flag_o) busy_cnt <= 32'h0;
        else busy_cnt <= busy_cnt + 32'h1;
    end
    a_start_sets_busy: assert property (clear_start_o |-> busy_flag_o)
        else $error("clear started without busy flag");
    a_latch_cleared: assert property (clear_start_o |-> !write_unlock_latch_o)
        else $error("unlock latch still set at clear start");
    a_start_needs_unlock: assert property ($rose(clear_start_o) |-> $past(write_unlock_latch_o))
        else $error("clear started while latch was clear");
    a_start_one_cycle: assert property (clear_start_o |=> !clear_start_o && busy_flag_o)
        else $error("clear start pulse wrong");
    a_busy_length: assert property ($fell(busy_flag_o) |->
        busy_cnt == (clear_block_o ? BLOCK_CLEAR_CYCLES : PAGE_CLEAR_CYCLES))
        else $error("busy flag length wrong");
    a_no_start_busy: assert property (busy_flag_o && $past(busy_flag_o) |-> !clear_start_o)
        else $error("clear started during a running cycle");
    a_region_aligned: assert property (clear_start_o |->
        (clear_block_o ? clear_addr_o[15:0] == 16'h0 : clear_addr_o[7:0] == 8'h0))
        else $error("clear region base not aligned");
    a_protect_kept: assert property (clear_start_o && hw_protect_i |-> clear_addr_o[18:16] != 3'h0)
        else $error("protected sector cleared");
    a_sleep_quiet: assert property (deep_sleep_o |-> !clear_start_o && !$rose(write_unlock_latch_o))
        else $error("command acted in deep sleep");
    a_standby_idle: assert property (standby_o |-> !busy_flag_o && !deep_sleep_o)
        else $error("standby shown while not idle");
endmodule : flash_ctl_properties
bind flash_erase_power_ctl flash_ctl_properties #(.PAGE_CLEAR_CYCLES(PAGE_CLEAR_CYCLES),
    .BLOCK_CLEAR_CYCLES(BLOCK_CLEAR_CYCLES)) flash_ctl_properties_i (.clock_i(clock_i),
    .sys_rst_i(sys_rst_i), .hw_protect_i(hw_protect_i), .clear_start_o(clear_start_o),
    .clear_block_o(clear_block_o), .clear_addr_o(clear_addr_o), .busy_flag_o(busy_flag_o),
    .write_unlock_latch_o(write_unlock_latch_o), .deep_sleep_o(deep_sleep_o), .standby_o(standby_o));
`default_nettype wire

/* tb/flash_host_model.sv */
// serial bus host that frames commands towards the flash block
// assumes the caller spaces frames; link clock 12 ns, still outside frames
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
    // serial link pins
    output var logic sclk_o,
    output var logic cs_n_o,
    output var logic sdi_o
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o  = 1'b0;
    end
    // ------------------------------------------------------------------
    // one frame, msb first; nbits other than the command length is a refusal test
    // ------------------------------------------------------------------
    task automatic frame(input logic [39:0] data, input int nbits);
        #24;
        cs_n_o = 1'b0;
        for (int i = nbits - 1; i >= 0; i--) begin
            sdi_o = data[i];
            #6 sclk_o = 1'b1;
            #6 sclk_o = 1'b0;
        end
        #6 cs_n_o = 1'b1;
        sdi_o = ~sdi_o; // released line must not keep its last value
    endtask : frame
endmodule : flash_host_model
`default_nettype wire

/* tb/flash_erase_power_ctl_test.sv */
// self-checking bench for flash_erase_power_ctl
// assumes the bound checker and flash_host_model on the link side
`timescale 1ns/1ps
`default_nettype none
module flash_erase_power_ctl_test;
    localparam int PAGE_C = 60;  // short counts keep the run brief
    localparam int BLOCK_C = 90;
    localparam int SLEEP_C = 40;
    localparam int WAKE_C = 40;
    localparam int HOLD_C = 200;
    logic clock_i, sys_rst_i, reset_n_i, por_hold_i, hw_protect_i, ext_cycle_busy_i;
    logic sclk, cs_n, sdi, clear_start_o, clear_block_o, busy_flag_o, latch, deep_sleep_o, standby_o;
    logic [18:0] clear_addr_o;
    int n_mismatch, n_checks;
    flash_erase_power_ctl #(.PAGE_CLEAR_CYCLES(PAGE_C), .BLOCK_CLEAR_CYCLES(BLOCK_C),
        .SLEEP_ENTRY_CYCLES(SLEEP_C), .WAKE_CYCLES(WAKE_C), .HOLDOFF_CYCLES(HOLD_C))
    flash_erase_power_ctl_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .sdi_i(sdi), .reset_n_i(reset_n_i), .por_hold_i(por_hold_i), .hw_protect_i(hw_protect_i),
        .ext_cycle_busy_i(ext_cycle_busy_i), .clear_start_o(clear_start_o), .clear_block_o(clear_block_o),
        .clear_addr_o(clear_addr_o), .busy_flag_o(busy_flag_o), .write_unlock_latch_o(latch),
        .deep_sleep_o(deep_sleep_o), .standby_o(standby_o));
    flash_host_model flash_host_model_i (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input string name, input logic [18:0] seen, input logic [18:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc
    // a frame of nbits, opcode first then address, shifted to fit the count
    task automatic send(input logic [7:0] op, input logic [23:0] addr, input int nbits);
        logic [39:0] d;
        d = {8'h0, op, addr};
        d = (nbits > 32) ? d << (nbits - 32) : d >> (32 - nbits);
        cyc(1);
        flash_host_model_i.frame(d, nbits);
    endtask : send
    // bounded wait: 0 busy flag, 1 deep sleep, 2 clear start
    task automatic wait_for(input int which, input logic v, input int bound);
        logic s;
        for (int i = 0; i <= bound; i++) begin
            @(posedge clock_i);
            #1;
            s = (which == 0) ? busy_flag_o : (which == 1) ? deep_sleep_o : clear_start_o;
            if (s === v) return;
        end
        n_mismatch++;
        $display("mismatch wait %0d expected %b timed out", which, v);
        print_verdict();
    endtask : wait_for
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {sys_rst_i, por_hold_i, reset_n_i, hw_protect_i, ext_cycle_busy_i} = 5'h18;
        n_mismatch = 0;
        n_checks = 0;
        cyc(16);
        sys_rst_i = 1'b0;
        cyc(4);
        por_hold_i = 1'b0;
        reset_n_i = 1'b1;
        chk("power up", {busy_flag_o, latch, deep_sleep_o}, 19'h0);
        send(flash_ctl_pkg::OP_UNLOCK, 24'h0, 8);
        cyc(8);
        chk("holdoff unlock", latch, 1'b0);
        cyc(HOLD_C);
        chk("standby", standby_o, 1'b1);
        send(flash_ctl_pkg::OP_PAGE_CLEAR, 24'h000400, 32);
        cyc(8);
        chk("clear locked", busy_flag_o, 1'b0);
        send(flash_ctl_pkg::OP_UNLOCK, 24'h0, 8);
        cyc(8);
        chk("unlock", latch, 1'b1);
        for (int n = 31; n <= 33; n += 2) begin
            send(flash_ctl_pkg::OP_BLOCK_CLEAR, 24'h030000, n);
            cyc(8);
            chk("bit count", busy_flag_o, 1'b0);
        end
        ext_cycle_busy_i = 1'b1;
        send(flash_ctl_pkg::OP_PAGE_CLEAR, 24'h010000, 32);
        cyc(8);
        chk("other cycle", busy_flag_o, 1'b0);
        ext_cycle_busy_i = 1'b0;
        hw_protect_i = 1'b1;
        send(flash_ctl_pkg::OP_PAGE_CLEAR, 24'h000500, 32);
        cyc(8);
        chk("protected page", busy_flag_o, 1'b0);
        send(flash_ctl_pkg::OP_BLOCK_CLEAR, 24'h080000, 32);
        cyc(8);
        chk("protected sector", busy_flag_o, 1'b0);
        hw_protect_i = 1'b0;
        send(flash_ctl_pkg::OP_PAGE_CLEAR, 24'hf81234, 32);
        wait_for(2, 1'b1, 12);
        chk("page region", {clear_block_o, clear_addr_o[17:0]}, 19'h01200);
        chk("page latch busy", {latch, busy_flag_o}, 19'h1);
        send(flash_ctl_pkg::OP_DEEP_SLEEP, 24'h0, 8);
        wait_for(0, 1'b0, PAGE_C);
        cyc(SLEEP_C + 10);
        chk("sleep while busy", deep_sleep_o, 1'b0);
        send(flash_ctl_pkg::OP_UNLOCK, 24'h0, 8);
        send(flash_ctl_pkg::OP_BLOCK_CLEAR, 24'h03ffff, 32);
        wait_for(2, 1'b1, 12);
        chk("sector region", {clear_block_o, clear_addr_o[17:0]}, 19'h70000);
        wait_for(0, 1'b0, BLOCK_C);
        send(flash_ctl_pkg::OP_DEEP_SLEEP, 24'h0, 8);
        cyc(SLEEP_C - 2);
        chk("sleep entry delay", deep_sleep_o, 1'b0);
        wait_for(1, 1'b1, 12);
        send(flash_ctl_pkg::OP_UNLOCK, 24'h0, 8);
        cyc(8);
        chk("unlock asleep", latch, 1'b0);
        send(flash_ctl_pkg::OP_WAKE, 24'h0, 9);
        cyc(WAKE_C + 10);
        chk("long wake", deep_sleep_o, 1'b1);
        send(flash_ctl_pkg::OP_WAKE, 24'h0, 8);
        cyc(WAKE_C - 2);
        chk("wake delay", deep_sleep_o, 1'b1);
        wait_for(1, 1'b0, 12);
        cyc(2);
        chk("standby after wake", standby_o, 1'b1);
        send(flash_ctl_pkg::OP_UNLOCK, 24'h0, 8);
        cyc(8);
        reset_n_i = 1'b0;
        cyc(6);
        chk("hold clears latch", latch, 1'b0);
        send(flash_ctl_pkg::OP_UNLOCK, 24'h0, 8);
        cyc(8);
        chk("hold ignores unlock", latch, 1'b0);
        reset_n_i = 1'b1;
        send(flash_ctl_pkg::OP_UNLOCK, 24'h0, 8);
        cyc(8);
        chk("holdoff restarts", latch, 1'b0);
        print_verdict();
    end
endmodule : flash_erase_power_ctl_test
`default_nettype wire
